// *** rtl/afm_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "afm_consts.svh"

// Behaviour
// - Leave all-frame mode when nothing pending
// - Alphanumeric vector raises all-frame counter
// - Decrement command lowers all-frame counter
// - End of frame emits status with frame
// - All-frame mode decodes and forwards everything
// - Type 001, instruction 000/010 assigns temporary
// - Capture temporary address, frame, window, sequence
// - Long 010 assignment takes frame from message
// - Sixteen temporary addresses, each with counter
// - Each assignment vector bumps its counter, which saturates at 15
// - Temporary address stays active until disables drain its counter
// - Secure, alphanumeric, hex vectors raise counter
module afm_ctrl
  import afm_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire afm_vec_s vec_in,
  input wire logic msg_valid,
  input wire logic [6:0] msg_assign_frame,
  input wire logic frame_end,
  input wire logic [6:0] frame_number,
  output afm_status_s status_out,
  output logic decode_all_frames,
  output logic [15:0] ta_active
);

  // Bus registers
  logic awready_q;
  logic wready_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic arready_q;
  logic rvalid_q;
  logic [1:0] rresp_q;
  logic [31:0] rdata_q;
  logic aw_hold_q;
  logic w_hold_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;

  // Block state
  logic force_all_frame_bit_q;
  afm_mode_e mode_q;
  afm_status_s status_q;
  logic [15:0] ta_active_q;
  logic [6:0] last_frame_q;
  logic [6:0] asg_frame_q;
  logic [3:0] asg_seq_q;
  logic [3:0] asg_idx_q;
  logic asg_window_q;
  logic asg_long_q;
  logic asg_exact_q;
  logic long_frame_pend_q;

  logic do_write;
  logic cmd_write;
  logic decrement_all_frame_bit;
  logic [15:0] disable_temp_address_bit;
  logic [7:0] af_count;
  logic [3:0] ta_count [16];
  logic [15:0] ta_inc;
  logic [15:0] ta_nonzero;
  logic anything_pending;
  afm_vclass_s vcls;

  function automatic logic addr_mapped(input logic [7:0] a);
    case (a)
      `AFM_OFF_CTRL, `AFM_OFF_CMD, `AFM_OFF_STATUS, `AFM_OFF_TA_MASK,
      `AFM_OFF_TA_CNT_LO, `AFM_OFF_TA_CNT_HI, `AFM_OFF_TA_ASSIGN,
      `AFM_OFF_FRAME: addr_mapped = 1'b1;
      default: addr_mapped = 1'b0;
    endcase
  endfunction

  // Packs eight 4-bit temporary counters starting at base
  function automatic logic [31:0] pack_ta(input logic [3:0] cnt [16], input int base);
    logic [31:0] w;
    w = 32'h0000_0000;
    for (int i = 0; i < 8; i++) begin
      w[i*4 +: 4] = cnt[base + i];
    end
    pack_ta = w;
  endfunction

  // ---------------- Vector classification ----------------

  afm_vec_decode u_vec_decode (
    .vec(vec_in),
    .cls(vcls)
  );

  // ---------------- AXI4-Lite write path ----------------

  assign do_write = aw_hold_q && w_hold_q && !bvalid_q;
  assign cmd_write = do_write && (awaddr_q == `AFM_OFF_CMD);
  assign decrement_all_frame_bit = cmd_write && wstrb_q[0] && wdata_q[`AFM_CMD_DEC_BIT];
  assign disable_temp_address_bit[7:0] = (cmd_write && wstrb_q[2])
    ? wdata_q[`AFM_CMD_DIS_LSB +: 8] : 8'h00;
  assign disable_temp_address_bit[15:8] = (cmd_write && wstrb_q[3])
    ? wdata_q[`AFM_CMD_DIS_LSB + 8 +: 8] : 8'h00;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      awready_q <= 1'b0;
    end else if (awready_q && s_axi_awvalid) begin
      awready_q <= 1'b0;
    end else begin
      awready_q <= !aw_hold_q && !bvalid_q;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wready_q <= 1'b0;
    end else if (wready_q && s_axi_wvalid) begin
      wready_q <= 1'b0;
    end else begin
      wready_q <= !w_hold_q && !bvalid_q;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      aw_hold_q <= 1'b0;
      awaddr_q <= 8'h00;
    end else if (awready_q && s_axi_awvalid) begin
      aw_hold_q <= 1'b1;
      awaddr_q <= {s_axi_awaddr[7:2], 2'h0};
    end else if (do_write) begin
      aw_hold_q <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      w_hold_q <= 1'b0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
    end else if (wready_q && s_axi_wvalid) begin
      w_hold_q <= 1'b1;
      wdata_q <= s_axi_wdata;
      wstrb_q <= s_axi_wstrb;
    end else if (do_write) begin
      w_hold_q <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= `AFM_RESP_OKAY;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      bresp_q <= addr_mapped(awaddr_q) ? `AFM_RESP_OKAY : `AFM_RESP_SLVERR;
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      force_all_frame_bit_q <= 1'(`AFM_RST_CTRL >> `AFM_CTRL_FORCE_BIT);
    end else if (do_write && awaddr_q == `AFM_OFF_CTRL && wstrb_q[0]) begin
      force_all_frame_bit_q <= wdata_q[`AFM_CTRL_FORCE_BIT];
    end
  end

  // ---------------- AXI4-Lite read path ----------------

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      arready_q <= 1'b0;
    end else if (arready_q && s_axi_arvalid) begin
      arready_q <= 1'b0;
    end else begin
      arready_q <= !rvalid_q;
    end
  end

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rvalid_q <= 1'b0;
      rresp_q <= `AFM_RESP_OKAY;
      rdata_q <= 32'h0000_0000;
    end else if (arready_q && s_axi_arvalid) begin
      rvalid_q <= 1'b1;
      rresp_q <= addr_mapped({s_axi_araddr[7:2], 2'h0}) ? `AFM_RESP_OKAY : `AFM_RESP_SLVERR;
      case ({s_axi_araddr[7:2], 2'h0})
        `AFM_OFF_CTRL: rdata_q <= {31'h0000_0000, force_all_frame_bit_q};
        `AFM_OFF_STATUS: rdata_q <= {16'h0000, af_count, 7'h00, mode_q == AFM_ALL_FRAME};
        `AFM_OFF_TA_MASK: rdata_q <= {16'h0000, ta_active_q};
        `AFM_OFF_TA_CNT_LO: rdata_q <= pack_ta(ta_count, 0);
        `AFM_OFF_TA_CNT_HI: rdata_q <= pack_ta(ta_count, 8);
        `AFM_OFF_TA_ASSIGN: rdata_q <= {8'h00, long_frame_pend_q, asg_exact_q, asg_long_q,
          asg_window_q, asg_idx_q, 4'h0, asg_seq_q, 1'b0, asg_frame_q};
        `AFM_OFF_FRAME: rdata_q <= {25'h000_0000, last_frame_q};
        default: rdata_q <= 32'h0000_0000;
      endcase
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ---------------- Counters ----------------

  // Message vectors raise it; host decrement lowers it, never below zero
  afm_sat_counter #(
    .W(`AFM_AF_CNT_W)
  ) u_af_counter (
    .clock(clock),
    .resetn(resetn),
    .inc(vcls.msg_vec),
    .dec(decrement_all_frame_bit),
    .count(af_count)
  );

  // One counter per temporary address
  for (genvar g = 0; g < `AFM_TA_NUM; g++) begin : g_ta
    assign ta_inc[g] = vcls.ta_assign && (vec_in.ta_index == 4'(g));
    afm_sat_counter #(
      .W(`AFM_TA_CNT_W)
    ) u_ta_counter (
      .clock(clock),
      .resetn(resetn),
      .inc(ta_inc[g]),
      .dec(disable_temp_address_bit[g]),
      .count(ta_count[g])
    );
    assign ta_nonzero[g] = ta_count[g] != 4'h0;
  end

  // Address stays live until its counter drains
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ta_active_q <= 16'h0000;
    end else begin
      ta_active_q <= ta_nonzero;
    end
  end

  // ---------------- Mode control ----------------

  assign anything_pending = (af_count != 8'h00) || (ta_nonzero != 16'h0000)
    || force_all_frame_bit_q;

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      mode_q <= AFM_NORMAL;
    end else begin
      case (mode_q)
        AFM_NORMAL: begin
          if (anything_pending || vcls.msg_vec || vcls.ta_assign) begin
            mode_q <= AFM_ALL_FRAME;
          end
        end
        AFM_ALL_FRAME: begin
          if (!anything_pending && !vcls.msg_vec && !vcls.ta_assign) begin
            mode_q <= AFM_NORMAL;
          end
        end
        default: mode_q <= AFM_NORMAL;
      endcase
    end
  end

  // ---------------- Temporary address assignment record ----------------

  // A vector and a message word in one cycle: the vector wins, a long 010 re-arms
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      asg_frame_q <= 7'h00;
      asg_seq_q <= 4'h0;
      asg_idx_q <= 4'h0;
      asg_window_q <= 1'b0;
      asg_long_q <= 1'b0;
      asg_exact_q <= 1'b0;
      long_frame_pend_q <= 1'b0;
    end else if (vcls.ta_assign) begin
      asg_idx_q <= vec_in.ta_index;
      asg_window_q <= vcls.window_form;
      asg_long_q <= vec_in.long_addr;
      if (vcls.window_form) begin
        asg_frame_q <= {vec_in.frame[6], 6'h00};
        asg_seq_q <= vec_in.seq;
        asg_exact_q <= 1'b0;
        long_frame_pend_q <= vec_in.long_addr;
      end else begin
        asg_frame_q <= vec_in.frame;
        asg_seq_q <= 4'h0;
        asg_exact_q <= 1'b1;
        long_frame_pend_q <= 1'b0;
      end
    end else if (long_frame_pend_q && msg_valid) begin
      asg_frame_q <= msg_assign_frame;
      asg_exact_q <= 1'b1;
      long_frame_pend_q <= 1'b0;
    end
  end

  // ---------------- End of frame status ----------------

  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      status_q <= '0;
      last_frame_q <= 7'h00;
    end else begin
      status_q.valid <= frame_end;
      status_q.eof <= frame_end;
      if (frame_end) begin
        status_q.frame <= frame_number;
        last_frame_q <= frame_number;
      end
    end
  end

  // ---------------- Outputs ----------------

  assign s_axi_awready = awready_q;
  assign s_axi_wready = wready_q;
  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rresp = rresp_q;
  assign s_axi_rdata = rdata_q;
  assign status_out = status_q;
  assign decode_all_frames = mode_q == AFM_ALL_FRAME;
  assign ta_active = ta_active_q;

endmodule

`default_nettype wire

// *** rtl/afm_consts.svh ***
`ifndef AFM_CONSTS_SVH
`define AFM_CONSTS_SVH

// Register byte offsets on the AXI4-Lite slave
`define AFM_OFF_CTRL 8'h00
`define AFM_OFF_CMD 8'h04
`define AFM_OFF_STATUS 8'h08
`define AFM_OFF_TA_MASK 8'h0C
`define AFM_OFF_TA_CNT_LO 8'h10
`define AFM_OFF_TA_CNT_HI 8'h14
`define AFM_OFF_TA_ASSIGN 8'h18
`define AFM_OFF_FRAME 8'h1C

// Field positions
`define AFM_CTRL_FORCE_BIT 0
`define AFM_CMD_DEC_BIT 0
`define AFM_CMD_DIS_LSB 16
`define AFM_STAT_MODE_BIT 0
`define AFM_STAT_CNT_LSB 8
`define AFM_ASSIGN_FRAME_LSB 0
`define AFM_ASSIGN_SEQ_LSB 8
`define AFM_ASSIGN_IDX_LSB 16
`define AFM_ASSIGN_FORM_BIT 20
`define AFM_ASSIGN_LONG_BIT 21
`define AFM_ASSIGN_EXACT_BIT 22
`define AFM_ASSIGN_PEND_BIT 23

// Widths
`define AFM_ADDR_W 8
`define AFM_DATA_W 32
`define AFM_AF_CNT_W 8
`define AFM_TA_CNT_W 4
`define AFM_TA_NUM 16
`define AFM_TA_IDX_W 4
`define AFM_FRAME_W 7
`define AFM_SEQ_W 4

// Vector type and short instruction codes
`define AFM_VT_SECURE 3'h0
`define AFM_VT_SHORT_INSTR 3'h1
`define AFM_VT_ALPHA 3'h5
`define AFM_VT_HEXBIN 3'h6
`define AFM_INSTR_TA_FRAME 3'h0
`define AFM_INSTR_TA_WINDOW 3'h2

// Reset values and bus answers
`define AFM_RST_CTRL 32'h0000_0000
`define AFM_RESP_OKAY 2'h0
`define AFM_RESP_SLVERR 2'h2

`endif

// *** rtl/afm_pkg.sv ***
package afm_pkg;

  // One received vector, as handed over by the word decoder
  typedef struct packed {
    logic valid;
    logic matched;
    logic long_addr;
    logic [2:0] vector_type_field;
    logic [2:0] short_instruction_field;
    logic [3:0] ta_index;
    logic [6:0] frame;
    logic [3:0] seq;
  } afm_vec_s;

  typedef struct packed {
    logic valid;
    logic eof;
    logic [6:0] frame;
  } afm_status_s;

  typedef struct packed {
    logic msg_vec;
    logic ta_assign;
    logic window_form;
  } afm_vclass_s;

  typedef enum logic {AFM_NORMAL, AFM_ALL_FRAME} afm_mode_e;

endpackage

// *** rtl/afm_sat_counter.sv ***
`timescale 1ns/1ps
`default_nettype none

module afm_sat_counter #(
  parameter int unsigned W = 8
) (
  input wire logic clock,
  input wire logic resetn,
  input wire logic inc,
  input wire logic dec,
  output logic [W-1:0] count
);

  logic [W-1:0] count_q;

  // Both at once cancel; floor at zero and ceiling at all ones
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      count_q <= '0;
    end else if (inc && !dec && count_q != {W{1'b1}}) begin
      count_q <= count_q + 1'b1;
    end else if (dec && !inc && count_q != '0) begin
      count_q <= count_q - 1'b1;
    end
  end

  assign count = count_q;

endmodule

`default_nettype wire

// *** rtl/afm_vec_decode.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "afm_consts.svh"

module afm_vec_decode
  import afm_pkg::*;
(
  input wire afm_vec_s vec,
  output afm_vclass_s cls
);

  function automatic logic is_msg_type(input logic [2:0] t);
    is_msg_type = (t == `AFM_VT_SECURE) || (t == `AFM_VT_ALPHA) || (t == `AFM_VT_HEXBIN);
  endfunction

  logic take;

  assign take = vec.valid && vec.matched;
  assign cls.msg_vec = take && is_msg_type(vec.vector_type_field);
  assign cls.ta_assign = take && (vec.vector_type_field == `AFM_VT_SHORT_INSTR)
    && ((vec.short_instruction_field == `AFM_INSTR_TA_FRAME)
    || (vec.short_instruction_field == `AFM_INSTR_TA_WINDOW));
  assign cls.window_form = vec.short_instruction_field == `AFM_INSTR_TA_WINDOW;

endmodule

`default_nettype wire

// *** testbench/afm_ctrl_props.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "afm_consts.svh"
module afm_ctrl_props
  import afm_pkg::*;
(
  input wire logic clock,
  input wire logic resetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire afm_vec_s vec_in,
  input wire logic frame_end,
  input wire logic [6:0] frame_number,
  input wire afm_status_s status_out,
  input wire logic decode_all_frames,
  input wire logic [15:0] ta_active
);
  default clocking @(posedge clock); endclocking
  default disable iff (!resetn);
  wire logic hit = vec_in.valid && vec_in.matched;
  wire logic msg_vec = hit && vec_in.vector_type_field inside {`AFM_VT_SECURE, `AFM_VT_ALPHA, `AFM_VT_HEXBIN};
  wire logic ta_vec = hit && vec_in.vector_type_field == `AFM_VT_SHORT_INSTR &&
    vec_in.short_instruction_field inside {`AFM_INSTR_TA_FRAME, `AFM_INSTR_TA_WINDOW};
  eof_status_a: assert property (
    frame_end |=> status_out.valid && status_out.eof && status_out.frame == $past(frame_number))
    else $error("status packet missing after frame end");
  status_quiet_a: assert property (
    !frame_end |=> !status_out.valid)
    else $error("status packet without frame end");
  msg_mode_a: assert property (
    msg_vec |=> decode_all_frames)
    else $error("message vector did not start all-frame decoding");
  ta_mode_a: assert property (
    ta_vec |=> decode_all_frames)
    else $error("assignment vector did not start all-frame decoding");
  ta_active_a: assert property (
    ta_vec |=> ##1 ta_active[$past(vec_in.ta_index, 2)])
    else $error("temporary counter not raised");
  mode_exit_a: assert property (
    $fell(decode_all_frames) |-> ta_active == 16'h0000)
    else $error("left all-frame mode with temporary address pending");
  write_resp_a: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  resp_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  cover property ($fell(decode_all_frames));
  cover property (s_axi_bvalid && s_axi_bresp == `AFM_RESP_SLVERR);
  cover property (ta_vec);
endmodule
`default_nettype wire

// *** testbench/afm_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "afm_consts.svh"
module afm_host_model (
  input wire logic clock,
  output logic [7:0] s_axi_awaddr,
  output logic [2:0] s_axi_awprot,
  output logic s_axi_awvalid,
  input wire logic s_axi_awready,
  output logic [31:0] s_axi_wdata,
  output logic [3:0] s_axi_wstrb,
  output logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  output logic s_axi_bready,
  output logic [7:0] s_axi_araddr,
  output logic [2:0] s_axi_arprot,
  output logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  output logic s_axi_rready
);
  initial {s_axi_awaddr, s_axi_awprot, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready,
    s_axi_araddr, s_axi_arprot, s_axi_arvalid, s_axi_rready} = '0;
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
    int n;
    n = 0;
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    forever begin
      @(posedge clock);
      n++;
      if (n > 40) tb_top.hang();
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid && s_axi_bready) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
      // Late bready makes the slave hold its response a cycle
      if (s_axi_bvalid) s_axi_bready <= 1'b1;
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    int n;
    n = 0;
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge clock);
      n++;
      if (n > 40) tb_top.hang();
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        d = s_axi_rdata;
        s_axi_rready <= 1'b0;
        break;
      end
    end
  endtask
  // One decrement per packet; the caller tracks fragments in flight
  task automatic dec_af();
    logic [1:0] r;
    wr(`AFM_OFF_CMD, 32'h1 << `AFM_CMD_DEC_BIT, 4'h1, r);
  endtask
  task automatic dis_ta(input logic [3:0] x);
    logic [1:0] r;
    wr(`AFM_OFF_CMD, 32'h1 << (`AFM_CMD_DIS_LSB + x), x[3] ? 4'h8 : 4'h4, r);
  endtask
endmodule
`default_nettype wire

// *** testbench/tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "afm_consts.svh"
module tb_top
  import afm_pkg::*;
;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic msg_valid, frame_end, decode_all_frames;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_word;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, wr_resp;
  logic [6:0] msg_assign_frame, frame_number;
  logic [15:0] ta_active;
  afm_vec_s vec_in;
  afm_status_s status_out;
  int err_total = 0;
  int samples_checked = 0;
  always #2.5 clock = ~clock;
  afm_ctrl dut_u (.clock, .resetn, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .vec_in, .msg_valid, .msg_assign_frame, .frame_end, .frame_number, .status_out, .decode_all_frames,
    .ta_active);
  afm_host_model host_u (.clock, .s_axi_awaddr, .s_axi_awprot, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arprot, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid, .s_axi_rready);
  task automatic finish_test();
    if (err_total == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic hang();
    err_total++;
    finish_test();
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    host_u.rd(a, rd_word);
    chk(rd_word, e);
  endtask
  task automatic vec(input logic [2:0] t, input logic [2:0] i, input logic [3:0] x, input logic l);
    @(posedge clock);
    vec_in <= '{1'b1, 1'b1, l, t, i, x, 7'h40, 4'h9};
    @(posedge clock);
    vec_in <= '0;
  endtask
  task automatic frm(input logic [6:0] f);
    @(posedge clock);
    frame_end <= 1'b1;
    frame_number <= f;
    @(posedge clock);
    frame_end <= 1'b0;
    #1;
    chk({23'h0, status_out.valid, status_out.eof, status_out.frame}, {23'h0, 2'b11, f});
  endtask
  initial begin
    vec_in = '0;
    msg_valid = 1'b0;
    msg_assign_frame = 7'h00;
    frame_end = 1'b0;
    frame_number = 7'h00;
    repeat (5) @(posedge clock);
    resetn <= 1'b1;
    rchk(`AFM_OFF_CTRL, `AFM_RST_CTRL);
    host_u.dec_af();
    rchk(`AFM_OFF_STATUS, 32'h0);
    vec(`AFM_VT_ALPHA, 3'h0, 4'h0, 1'b0);
    rchk(`AFM_OFF_STATUS, 32'h0000_0101);
    chk({31'h0, decode_all_frames}, 32'h1);
    host_u.wr(8'h40, 32'h1, 4'hF, wr_resp);
    chk({30'h0, wr_resp}, {30'h0, `AFM_RESP_SLVERR});
    host_u.rd(8'h44, rd_word);
    chk({s_axi_rresp, rd_word[29:0]}, {`AFM_RESP_SLVERR, 30'h0});
    host_u.rd(8'h0B, rd_word);
    chk({s_axi_rresp, rd_word[29:0]}, {`AFM_RESP_OKAY, 30'h0000_0101});
    rchk(`AFM_OFF_STATUS, 32'h0000_0101);
    frm(7'h11);
    vec(`AFM_VT_ALPHA, 3'h0, 4'h0, 1'b0);
    rchk(`AFM_OFF_STATUS, 32'h0000_0201);
    host_u.dec_af();
    rchk(`AFM_OFF_STATUS, 32'h0000_0101);
    frm(7'h12);
    rchk(`AFM_OFF_FRAME, 32'h0000_0012);
    vec(`AFM_VT_ALPHA, 3'h0, 4'h0, 1'b0);
    host_u.dec_af();
    host_u.dec_af();
    rchk(`AFM_OFF_STATUS, 32'h0);
    vec(`AFM_VT_SECURE, 3'h0, 4'h0, 1'b0);
    vec(`AFM_VT_HEXBIN, 3'h0, 4'h0, 1'b0);
    vec(3'h3, 3'h0, 4'h0, 1'b0);
    rchk(`AFM_OFF_STATUS, 32'h0000_0201);
    repeat (2) host_u.dec_af();
    vec(`AFM_VT_SHORT_INSTR, `AFM_INSTR_TA_FRAME, 4'h3, 1'b0);
    vec(`AFM_VT_SHORT_INSTR, `AFM_INSTR_TA_WINDOW, 4'h3, 1'b0);
    vec(`AFM_VT_SHORT_INSTR, 3'h1, 4'h3, 1'b0);
    vec(`AFM_VT_SHORT_INSTR, `AFM_INSTR_TA_FRAME, 4'hF, 1'b0);
    frm(7'h40);
    rchk(`AFM_OFF_TA_CNT_LO, 32'h0000_2000);
    rchk(`AFM_OFF_TA_CNT_HI, 32'h1000_0000);
    chk({16'h0, ta_active}, 32'h0000_8008);
    rchk(`AFM_OFF_STATUS, 32'h1);
    host_u.dis_ta(4'h3);
    rchk(`AFM_OFF_TA_MASK, 32'h0000_8008);
    host_u.dis_ta(4'h3);
    host_u.dis_ta(4'h3);
    host_u.dis_ta(4'hF);
    rchk(`AFM_OFF_TA_CNT_LO, 32'h0);
    rchk(`AFM_OFF_STATUS, 32'h0);
    vec(`AFM_VT_SHORT_INSTR, `AFM_INSTR_TA_WINDOW, 4'h5, 1'b1);
    @(posedge clock);
    msg_valid <= 1'b1;
    msg_assign_frame <= 7'h25;
    @(posedge clock);
    msg_valid <= 1'b0;
    host_u.rd(`AFM_OFF_TA_ASSIGN, rd_word);
    chk({15'h0, rd_word[22], rd_word[20], rd_word[19:16], rd_word[11:8], rd_word[6:0]},
      {15'h0, 2'b11, 4'h5, 4'h9, 7'h25});
    host_u.dis_ta(4'h5);
    host_u.wr(`AFM_OFF_CTRL, 32'h1, 4'h1, wr_resp);
    rchk(`AFM_OFF_STATUS, 32'h1);
    host_u.wr(`AFM_OFF_CTRL, 32'h0, 4'h1, wr_resp);
    rchk(`AFM_OFF_STATUS, 32'h0);
    finish_test();
  end
endmodule
bind afm_ctrl afm_ctrl_props props_u (.clock, .resetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .vec_in, .frame_end, .frame_number, .status_out,
  .decode_all_frames, .ta_active);
`default_nettype wire
